// File: hdl/dssrpm_top.sv
`include "dssrpm_defines.svh"
`default_nettype none
module dssrpm_top (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic driveReset,
  input wire logic routedInputOne,
  input wire logic routedInputTwo,
  input wire logic routedInputThree,
  input wire logic atSpeedCondition,
  input wire dssrpm_pkg::dssrpm_fb_s feedback,
  output logic driveEnable,
  output logic runReverse,
  output logic ffActive,
  output logic [15:0] postRampSpeedReference
);

  logic [2:0] macroSel_r;
  logic [2:0] posMode_r;
  logic [2:0] activeMacro_r;
  logic spinCatch_r;
  logic latchEn_r;
  logic activeLatch_r;
  logic loadPend_r;
  logic [7:0] gain_r;
  logic [15:0] rampStep_r;
  dssrpm_pkg::dssrpm_code_t dest_r [3];
  dssrpm_pkg::dssrpm_code_t activeDest_r [3];
  dssrpm_pkg::dssrpm_fn_s fnHit [3];
  dssrpm_pkg::dssrpm_fn_s anyHit;
  dssrpm_pkg::dssrpm_fn_s anyOn;
  logic [2:0] termIn;
  logic wbReq;
  logic wrEn;
  logic [5:0] wbWord;
  logic ack_r;
  logic [31:0] rdData_r;
  logic [31:0] rdNxt;
  dssrpm_pkg::dssrpm_seq_e seq_r;
  dssrpm_pkg::dssrpm_seq_e seq_nxt;
  logic driveEnable_r;
  logic enPrev_r;
  logic fwdReq;
  logic revReq;
  logic permitOk;
  logic fastOk;
  logic ffOn;
  logic rigidOn;
  logic nonRigidOn;
  logic orientOn;
  logic ffActive_r;
  logic signed [15:0] posErr_r;
  logic signed [15:0] posCorr_r;
  logic signed [15:0] postRef_r;
  logic signed [15:0] ffSpeed;
  logic signed [15:0] target;
  logic signed [23:0] product;
  logic signed [16:0] rampDiff;
  logic signed [16:0] stepS;

  function automatic dssrpm_pkg::dssrpm_code_t macroDest(input logic [2:0] sel, input int idx);
    dssrpm_pkg::dssrpm_code_t c;
    case (idx)
      0: c = sel[0] ? `DSSRPM_CODE_PERM : `DSSRPM_CODE_FDIS;
      1: c = sel[1] ? `DSSRPM_CODE_RUN : `DSSRPM_CODE_FWD;
      default: c = sel[1] ? `DSSRPM_CODE_DIR : `DSSRPM_CODE_REV;
    endcase
    return c;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
    return {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  assign termIn = {routedInputThree, routedInputTwo, routedInputOne};
  assign wbReq = wb_cyc_i & wb_stb_i;
  assign wbWord = wb_adr_i[7:2];
  // writes land on the edge where the master samples ack
  assign wrEn = wbReq & wb_we_i & ack_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdData_r;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      ack_r <= 1'b0;
      rdData_r <= 32'h0000_0000;
    end else if (clkEn) begin
      ack_r <= wbReq & ~ack_r;
      if (wbReq & ~ack_r) begin
        rdData_r <= rdNxt;
      end
    end
  end

  always_comb begin
    rdNxt = 32'h0000_0000;
    case (wbWord)
      `DSSRPM_IDX_MACRO: rdNxt = {29'h0000_0000, macroSel_r};
      `DSSRPM_IDX_SPIN: rdNxt = {31'h0000_0000, spinCatch_r};
      `DSSRPM_IDX_POSMODE: rdNxt = {29'h0000_0000, posMode_r};
      `DSSRPM_IDX_LATCH: rdNxt = {31'h0000_0000, latchEn_r};
      `DSSRPM_IDX_DEST0: rdNxt = {16'h0000, dest_r[0]};
      `DSSRPM_IDX_DEST0 + 6'h01: rdNxt = {16'h0000, dest_r[1]};
      `DSSRPM_IDX_DEST0 + 6'h02: rdNxt = {16'h0000, dest_r[2]};
      `DSSRPM_IDX_GAIN: rdNxt = {24'h0000_00, gain_r};
      `DSSRPM_IDX_RAMP: rdNxt = {16'h0000, rampStep_r};
      `DSSRPM_IDX_STATUS: rdNxt = {21'h00_0000, ffActive_r, nonRigidOn, orientOn, seq_r,
        driveEnable_r, activeLatch_r, activeMacro_r};
      `DSSRPM_IDX_SPEEDREF: rdNxt = {16'h0000, postRef_r};
      default: rdNxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      macroSel_r <= `DSSRPM_RST_MACRO;
      spinCatch_r <= `DSSRPM_RST_SPIN;
      posMode_r <= `DSSRPM_RST_POSMODE;
      gain_r <= `DSSRPM_RST_GAIN;
      rampStep_r <= `DSSRPM_RST_RAMP;
    end else if (clkEn && wrEn && wb_sel_i[0]) begin
      case (wbWord)
        `DSSRPM_IDX_MACRO: begin
          if (wb_dat_i[2:0] <= `DSSRPM_MACRO_MAX) begin
            macroSel_r <= wb_dat_i[2:0]; // RL1
          end
        end
        `DSSRPM_IDX_SPIN: spinCatch_r <= wb_dat_i[0];
        `DSSRPM_IDX_POSMODE: begin
          if (wb_dat_i[2:0] <= `DSSRPM_POSMODE_MAX) begin
            posMode_r <= wb_dat_i[2:0]; // RL13
          end
        end
        `DSSRPM_IDX_GAIN: gain_r <= wb_dat_i[7:0];
        `DSSRPM_IDX_RAMP: rampStep_r <= merge16(rampStep_r, wb_dat_i, wb_sel_i);
        default: ;
      endcase
    end else if (clkEn && wrEn && wb_sel_i[1] && wbWord == `DSSRPM_IDX_RAMP) begin
      rampStep_r <= merge16(rampStep_r, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      latchEn_r <= 1'b0;
    end else if (clkEn) begin
      if (macroSel_r <= `DSSRPM_MACRO_LAST) begin
        latchEn_r <= macroSel_r[0]; // RL2 RL5
      end else if (wrEn && wb_sel_i[0] && wbWord == `DSSRPM_IDX_LATCH) begin
        latchEn_r <= wb_dat_i[0]; // RL3
      end
    end
  end

  // snapshot taken after reset release and on every drive reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      loadPend_r <= 1'b1;
      activeMacro_r <= `DSSRPM_RST_MACRO;
      activeLatch_r <= 1'b0;
    end else if (clkEn) begin
      loadPend_r <= driveReset;
      if (loadPend_r) begin
        activeMacro_r <= macroSel_r; // RL4
        activeLatch_r <= latchEn_r;
      end
    end
  end

  for (genvar g = 0; g < 3; g++) begin : gTerm
    always_ff @(posedge core_clk) begin
      if (reset) begin
        dest_r[g] <= macroDest(`DSSRPM_RST_MACRO, g);
      end else if (clkEn) begin
        if (macroSel_r <= `DSSRPM_MACRO_LAST) begin
          dest_r[g] <= macroDest(macroSel_r, g); // RL2 RL5
        end else if (wrEn && wbWord == `DSSRPM_IDX_DEST0 + 6'(g)) begin
          dest_r[g] <= merge16(dest_r[g], wb_dat_i, wb_sel_i); // RL3 RL6
        end
      end
    end

    always_ff @(posedge core_clk) begin
      if (reset) begin
        activeDest_r[g] <= macroDest(`DSSRPM_RST_MACRO, g);
      end else if (clkEn && loadPend_r) begin
        activeDest_r[g] <= dest_r[g]; // RL4
      end
    end

    always_comb begin
      fnHit[g] = '0;
      fnHit[g].fastDisable = activeDest_r[g] == `DSSRPM_CODE_FDIS;
      fnHit[g].runPermit = activeDest_r[g] == `DSSRPM_CODE_PERM;
      fnHit[g].runForward = activeDest_r[g] == `DSSRPM_CODE_FWD;
      fnHit[g].runReverse = activeDest_r[g] == `DSSRPM_CODE_REV;
      fnHit[g].run = activeDest_r[g] == `DSSRPM_CODE_RUN;
      fnHit[g].dirSelect = activeDest_r[g] == `DSSRPM_CODE_DIR;
    end
  end

  always_comb begin
    anyHit = '0;
    anyOn = '0;
    for (int i = 0; i < 3; i++) begin
      anyHit = anyHit | fnHit[i];
      anyOn = anyOn | (fnHit[i] & {6{termIn[i]}});
    end
  end

  assign fwdReq = anyOn.runForward | (anyOn.run & ~anyOn.dirSelect);
  assign revReq = anyOn.runReverse | (anyOn.run & anyOn.dirSelect);
  // with latching on, only a routed and active permit lets the drive run
  assign permitOk = ~activeLatch_r | anyOn.runPermit;
  // an unrouted fast disable never blocks the drive
  assign fastOk = ~anyHit.fastDisable | anyOn.fastDisable;

  always_comb begin
    seq_nxt = seq_r;
    case (seq_r)
      dssrpm_pkg::SQ_IDLE: begin
        if (permitOk && fwdReq && !revReq) begin
          seq_nxt = dssrpm_pkg::SQ_FWD;
        end else if (permitOk && revReq && !fwdReq) begin
          seq_nxt = dssrpm_pkg::SQ_REV;
        end
      end
      dssrpm_pkg::SQ_FWD: begin
        if (!permitOk || (!activeLatch_r && !fwdReq)) begin
          seq_nxt = dssrpm_pkg::SQ_IDLE; // RL9
        end
      end
      dssrpm_pkg::SQ_REV: begin
        if (!permitOk || (!activeLatch_r && !revReq)) begin
          seq_nxt = dssrpm_pkg::SQ_IDLE; // RL9
        end
      end
      default: seq_nxt = dssrpm_pkg::SQ_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      seq_r <= dssrpm_pkg::SQ_IDLE;
      driveEnable_r <= 1'b0;
      enPrev_r <= 1'b0;
    end else if (clkEn) begin
      seq_r <= seq_nxt;
      driveEnable_r <= (seq_nxt != dssrpm_pkg::SQ_IDLE) && fastOk;
      enPrev_r <= driveEnable_r;
    end
  end

  assign driveEnable = driveEnable_r;
  assign runReverse = seq_r == dssrpm_pkg::SQ_REV;

  assign ffOn = posMode_r == 3'h1 || posMode_r == 3'h3;
  assign rigidOn = posMode_r == 3'h1 || posMode_r == 3'h2;
  assign nonRigidOn = posMode_r == 3'h3 || posMode_r == 3'h4;
  assign orientOn = posMode_r == 3'h5 || posMode_r == 3'h6;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      posErr_r <= 16'sh0000;
      ffActive_r <= 1'b0;
    end else if (clkEn) begin
      ffActive_r <= ffOn; // RL14
      if (!driveEnable_r || !(rigidOn || nonRigidOn)) begin
        posErr_r <= 16'sh0000;
      end else if (rigidOn || atSpeedCondition) begin
        posErr_r <= posErr_r + feedback.refPosDelta - feedback.fbPosDelta; // RL15 RL16
      end else begin
        posErr_r <= 16'sh0000; // RL16
      end
    end
  end

  assign ffActive = ffActive_r;
  // proportional term only; the posErr_r sum is the sole integrator in the loop
  assign product = posErr_r * $signed({1'b0, gain_r}); // RL18
  assign ffSpeed = ffOn ? feedback.refEncoderSpeed : 16'sh0000; // RL17
  assign target = feedback.speedDemand + ffSpeed + posCorr_r; // RL17
  assign rampDiff = 17'(target) - 17'(postRef_r);
  assign stepS = $signed({1'b0, rampStep_r});

  always_ff @(posedge core_clk) begin
    if (reset) begin
      posCorr_r <= 16'sh0000;
    end else if (clkEn) begin
      posCorr_r <= product[`DSSRPM_GAIN_SHIFT +: 16]; // RL18
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      postRef_r <= 16'sh0000;
    end else if (clkEn) begin
      if (!driveEnable_r) begin
        postRef_r <= 16'sh0000;
      end else if (!enPrev_r) begin
        postRef_r <= spinCatch_r ? feedback.measuredSpeed : 16'sh0000; // RL10 RL11
      end else if (rampDiff > stepS) begin
        postRef_r <= postRef_r + rampStep_r; // RL10
      end else if (rampDiff < -stepS) begin
        postRef_r <= postRef_r - rampStep_r;
      end else begin
        postRef_r <= target;
      end
    end
  end

  assign postRampSpeedReference = postRef_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_enableStart;
    clkEn && driveEnable_r && !enPrev_r;
  endsequence

  property p_macroRewrite;
    (clkEn && macroSel_r <= `DSSRPM_MACRO_LAST) |=> dest_r[1] == macroDest($past(macroSel_r), 1);
  endproperty
  a_macroRewrite: assert property (p_macroRewrite) else $error("macro routing not rewritten"); // RL2
  property p_macroLatch;
    (clkEn && macroSel_r <= `DSSRPM_MACRO_LAST) |=> latchEn_r == $past(macroSel_r[0]);
  endproperty
  a_macroLatch: assert property (p_macroLatch) else $error("latch bit differs from macro"); // RL5
  property p_userHold;
    (clkEn && macroSel_r == `DSSRPM_MACRO_MAX && !wrEn) |=> $stable(dest_r[0]) && $stable(latchEn_r);
  endproperty
  a_userHold: assert property (p_userHold) else $error("user routing changed unbidden"); // RL3 RL6
  property p_activeOnReset;
    !loadPend_r |=> $stable(activeMacro_r) && $stable(activeDest_r[2]);
  endproperty
  a_activeOnReset: assert property (p_activeOnReset) else $error("routing applied without reset"); // RL4
  property p_permitDrop;
    (clkEn && activeLatch_r && !anyOn.runPermit) |=> !driveEnable_r && (seq_r == dssrpm_pkg::SQ_IDLE);
  endproperty
  a_permitDrop: assert property (p_permitDrop) else $error("drive runs without permit"); // RL9
  property p_startZero;
    s_enableStart ##0 !spinCatch_r |=> postRef_r == 16'sh0000;
  endproperty
  a_startZero: assert property (p_startZero) else $error("reference not started at zero"); // RL10
  property p_startCatch;
    s_enableStart ##0 spinCatch_r |=> postRef_r == $past(feedback.measuredSpeed);
  endproperty
  a_startCatch: assert property (p_startCatch) else $error("reference not loaded with speed"); // RL11
  property p_ffMode;
    (clkEn && (posMode_r == 3'h2 || posMode_r == 3'h4)) |=> !ffActive;
  endproperty
  a_ffMode: assert property (p_ffMode) else $error("feed-forward active in mode 2 or 4"); // RL14
  property p_slip;
    (clkEn && nonRigidOn && !atSpeedCondition) |=> posErr_r == 16'sh0000;
  endproperty
  a_slip: assert property (p_slip) else $error("non-rigid loop acted off speed"); // RL16

endmodule
`default_nettype wire

// File: hdl/dssrpm_defines.svh
// Behaviour
// RL1 - macro selector accepts values 0 to 4
// RL2 - macros 0-3 keep rewriting routing and latching
// RL3 - macro 4 leaves routing user writable
// RL4 - new macro routing applies after drive reset
// RL5 - macro table fixes each terminal function
// RL6 - switching to 4 keeps last routing
// RL7 - user restores defaults by hand
// RL8 - latching needs user-driven run permit input
// RL9 - dropping run permit clears latch, stops
// RL10 - no spin catch: reference starts at zero
// RL11 - spin catch: reference loads measured speed
// RL12 - user clears spin catch when unneeded
// RL13 - position mode accepts 0 to 6
// RL14 - feed-forward only in modes 1 and 3
// RL15 - rigid mode always accumulates position error
// RL16 - non-rigid loop acts only at speed
// RL17 - feed-forward reference speed enters speed path
// RL18 - position loop is proportional only
`ifndef DSSRPM_DEFINES_SVH
`define DSSRPM_DEFINES_SVH

`define DSSRPM_IDX_MACRO 6'h00
`define DSSRPM_IDX_SPIN 6'h01
`define DSSRPM_IDX_POSMODE 6'h02
`define DSSRPM_IDX_LATCH 6'h03
`define DSSRPM_IDX_DEST0 6'h04
`define DSSRPM_IDX_GAIN 6'h07
`define DSSRPM_IDX_RAMP 6'h08
`define DSSRPM_IDX_STATUS 6'h09
`define DSSRPM_IDX_SPEEDREF 6'h0a

`define DSSRPM_RST_MACRO 3'h0
`define DSSRPM_RST_SPIN 1'h1
`define DSSRPM_RST_POSMODE 3'h0
`define DSSRPM_RST_GAIN 8'h10
`define DSSRPM_RST_RAMP 16'h0010

`define DSSRPM_MACRO_LAST 3'h3
`define DSSRPM_MACRO_MAX 3'h4
`define DSSRPM_POSMODE_MAX 3'h6
`define DSSRPM_GAIN_SHIFT 4

`define DSSRPM_CODE_FDIS 16'h061d
`define DSSRPM_CODE_FWD 16'h061e
`define DSSRPM_CODE_REV 16'h0620
`define DSSRPM_CODE_DIR 16'h0621
`define DSSRPM_CODE_RUN 16'h0622
`define DSSRPM_CODE_PERM 16'h0627

`endif

// File: hdl/dssrpm_pkg.sv
`default_nettype none
package dssrpm_pkg;
  typedef logic [15:0] dssrpm_code_t;

  typedef enum logic [2:0] {
    SQ_IDLE = 3'h1,
    SQ_FWD = 3'h2,
    SQ_REV = 3'h4
  } dssrpm_seq_e;

  typedef struct packed {
    logic fastDisable;
    logic runPermit;
    logic runForward;
    logic runReverse;
    logic run;
    logic dirSelect;
  } dssrpm_fn_s;

  typedef struct packed {
    logic signed [15:0] speedDemand;
    logic signed [15:0] measuredSpeed;
    logic signed [15:0] refEncoderSpeed;
    logic signed [15:0] refPosDelta;
    logic signed [15:0] fbPosDelta;
  } dssrpm_fb_s;
endpackage
`default_nettype wire

// File: bench/dssrpm_ctrl_model.sv
`default_nettype none
module dssrpm_ctrl_model (
  input wire logic core_clk,
  input wire logic [2:0] want,
  input wire logic latchMode,
  input wire logic slow,
  output logic routedInputOne,
  output logic routedInputTwo,
  output logic routedInputThree
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] held;
  logic [2:0] req;
  assign req = slow ? held : want;
  initial begin
    held = 3'h0;
    routedInputOne = 1'b0;
    routedInputTwo = 1'b0;
    routedInputThree = 1'b0;
  end
  // in latch mode, run requests only once the permit line already stands high
  always @(posedge core_clk) begin
    held <= want;
    routedInputOne <= req[0];
    routedInputTwo <= req[1] & (~latchMode | routedInputOne);
    routedInputThree <= req[2] & (~latchMode | routedInputOne);
  end
endmodule
`default_nettype wire

// File: bench/dssrpm_top_tb.sv
`default_nettype none
module dssrpm_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, reset, clkEn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, driveReset, atSpeedCondition;
  logic driveEnable, runReverse, ffActive, routedInputOne, routedInputTwo, routedInputThree;
  logic latchMode, slow;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic [3:0] wb_sel_i;
  logic [15:0] postRampSpeedReference;
  logic [2:0] want;
  dssrpm_pkg::dssrpm_fb_s feedback;
  int errors, compares, lfsr, ms, dm;
  dssrpm_top dut (.core_clk, .reset, .clkEn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i,
    .wb_sel_i, .wb_dat_o, .wb_ack_o, .driveReset, .routedInputOne, .routedInputTwo, .routedInputThree,
    .atSpeedCondition, .feedback, .driveEnable, .runReverse, .ffActive, .postRampSpeedReference);
  dssrpm_ctrl_model ctrl (.core_clk, .want, .latchMode, .slow, .routedInputOne, .routedInputTwo,
    .routedInputThree);
  function automatic int nextRand(int s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'h3;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    check("ack", wb_ack_o, 1);
    if (wb_ack_o !== 1'b1) conclude();
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(logic [7:0] a, string name, logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(name, rdat, exp);
  endtask
  task automatic useMacro(int m);
    wb(1'b1, 8'h00, m);
    latchMode <= m[0];
    driveReset <= 1'b1;
    @(posedge core_clk);
    driveReset <= 1'b0;
    tick(3);
    wb(1'b0, 8'h24, 32'h0);
    check("active macro", rdat[3:0], {m[0], m[2:0]});
  endtask
  task automatic waitRef(string name, int t);
    int n;
    n = 0;
    while (postRampSpeedReference !== t[15:0] && n < 400) begin
      @(posedge core_clk);
      n++;
    end
    check(name, postRampSpeedReference, t[15:0]);
    if (n >= 400) conclude();
  endtask
  task automatic drive(logic [2:0] w, string name, logic en);
    want <= w;
    tick(5);
    check(name, driveEnable, en);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    reset = 1'b1;
    clkEn = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, driveReset, latchMode, slow} = '0;
    {wb_adr_i, wb_dat_i, wb_sel_i, want} = '0;
    atSpeedCondition = 1'b1;
    feedback = '0;
    errors = 0;
    compares = 0;
    lfsr = 92867;
    tick(5);
    reset <= 1'b0;
    @(posedge core_clk);
    check("enable after reset", driveEnable, 0);
    rd(8'h00, "macro", 0);
    rd(8'h04, "spin", 1);
    rd(8'h08, "posmode", 0);
    wb(1'b1, 8'h3c, 32'hffff_ffff);
    rd(8'h3c, "unmapped", 0);
    for (int m = 0; m < 4; m++) begin
      wb(1'b1, 8'h00, m);
      wb(1'b1, 8'h10, 32'h0000_0a21);
      rd(8'h10, "dest one", m[0] ? 16'h0627 : 16'h061d);
      rd(8'h14, "dest two", m[1] ? 16'h0622 : 16'h061e);
      rd(8'h18, "dest three", m[1] ? 16'h0621 : 16'h0620);
      rd(8'h0c, "latch", m[0]);
      wb(1'b0, 8'h24, 32'h0);
      check("active before reset", rdat[2:0], 0);
    end
    wb(1'b1, 8'h00, 5);
    rd(8'h00, "macro over range", 3);
    wb(1'b1, 8'h00, 4);
    rd(8'h10, "kept dest", 16'h0627);
    wb(1'b1, 8'h0c, 0);
    wb(1'b1, 8'h10, 16'h0a21);
    wb(1'b1, 8'h14, 16'h061e);
    wb(1'b1, 8'h18, 16'h0620);
    rd(8'h0c, "user latch", 0);
    rd(8'h10, "user dest", 16'h0a21);
    useMacro(0);
    for (int s = 0; s < 2; s++) begin
      lfsr = nextRand(lfsr);
      ms = 16 + lfsr[7:0];
      dm = ms + 256;
      slow <= lfsr[8];
      feedback.measuredSpeed <= ms[15:0];
      feedback.speedDemand <= dm[15:0];
      wb(1'b1, 8'h04, s);
      want <= 3'b011;
      for (int n = 0; n < 20 && postRampSpeedReference === 16'h0; n++) @(posedge core_clk);
      check("first ref", postRampSpeedReference, s ? ms : 16);
      waitRef("ramped ref", dm);
      drive(3'b001, "released", 0);
    end
    drive(3'b101, "reverse run", 1);
    check("reverse", runReverse, 1);
    drive(3'b100, "fast disable", 0);
    feedback.refEncoderSpeed <= 16'h0040;
    want <= 3'b011;
    for (int p = 0; p < 8; p++) begin
      wb(1'b1, 8'h08, p);
      rd(8'h08, "posmode", p == 7 ? 6 : p);
      check("feed forward", ffActive, p == 1 || p == 3);
      waitRef("ff ref", (p == 1 || p == 3) ? dm + 64 : dm);
    end
    feedback.refPosDelta <= 16'h0001;
    atSpeedCondition <= 1'b0;
    wb(1'b1, 8'h08, 4);
    tick(50);
    check("slip ref", postRampSpeedReference, dm);
    wb(1'b1, 8'h08, 2);
    tick(50);
    check("rigid catch up", $signed(postRampSpeedReference) > dm, 1);
    clkEn <= 1'b0;
    tick(1);
    ms = postRampSpeedReference;
    tick(8);
    check("frozen ref", postRampSpeedReference, ms);
    clkEn <= 1'b1;
    feedback.refPosDelta <= 16'h0000;
    wb(1'b1, 8'h08, 0);
    useMacro(2);
    drive(3'b111, "run select", 1);
    check("dir select", runReverse, 1);
    drive(3'b000, "stop", 0);
    useMacro(1);
    drive(3'b010, "no permit", 0);
    drive(3'b011, "latched start", 1);
    drive(3'b001, "latched hold", 1);
    drive(3'b000, "permit drop", 0);
    wb(1'b1, 8'h04, 0);
    conclude();
  end
endmodule
`default_nettype wire
